// File: dv/ssc_peer.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// external spi slave, mode 0, fixed reply word
module ssc_peer #(
	parameter logic [15:0] RESP = 16'hA5C3 // reply pattern, msb first
) (
	input  wire logic        sclk,    // bus clock
	input  wire logic        mosi,    // data from master
	input  wire logic        ssel_n,  // select, active low
	output var  logic        miso,    // data to master
	output var  logic [15:0] rx_word, // bits taken this frame
	output var  logic [4:0]  nbits    // clock rises this frame
);
	logic [15:0] sh;

	// quiet start, nothing captured yet
	initial begin
		miso = 1'h0;
		rx_word = 16'h0000;
		nbits = 5'h00;
	end
	// frame start loads the reply and clears the capture
	always @(negedge ssel_n) begin
		sh = RESP;
		miso = RESP[15];
		rx_word = 16'h0000;
		nbits = 5'h00;
	end
	// mode 0: take data on the rising edge
	always @(posedge sclk) if (!ssel_n) begin
		rx_word = {rx_word[14:0], mosi};
		nbits = nbits + 5'h01;
	end
	// next reply bit after the falling edge
	always @(negedge sclk) if (!ssel_n) begin
		sh = {sh[14:0], 1'h0};
		miso = sh[15];
	end
	// released line flips, so a stale bit never looks valid
	always @(posedge ssel_n) miso = ~miso;
endmodule : ssc_peer
`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "ssc_map.svh"
// ==========================================
// bench top
module tb_top
	import ssc_pkg::*;
;
	typedef struct packed {
		logic [3:0]  sz;
		logic [1:0]  fmt;
		logic        pol;
		logic        pha;
		logic [7:0]  rate;
		logic [7:0]  pre;
		logic        lp;
		logic [15:0] tx;
		logic [15:0] ex;
	} ssc_row_s;

	logic         ref_clk;
	logic         rstn;
	logic         read;
	logic         write;
	logic         waitrequest;
	logic         tb_ssel_n;
	logic [31:0]  address;
	logic [31:0]  writedata;
	logic [31:0]  readdata;
	ssc_pin_in_s  pins_in;
	ssc_pin_out_s pins_out;
	logic         sclk_w;
	logic         mosi_w;
	logic         miso_w;
	logic         ssel_w;
	logic         peer_miso;
	logic [15:0]  peer_rx;
	logic [4:0]   peer_n;
	int           err_count;
	int           n_tests;
	int           cyc = 0;
	int           last_rise = 0;
	int           per = 0;
	// first three rows talk to the peer, the rest loop back
	ssc_row_s     rows [8] = '{
		'{4'h7, 2'h0, 1'h0, 1'h0, 8'h03, 8'h04, 1'h0, 16'h005A, 16'h00A5},
		'{4'hF, 2'h0, 1'h0, 1'h0, 8'h01, 8'h06, 1'h0, 16'hC3E1, 16'hA5C3},
		'{4'h3, 2'h0, 1'h0, 1'h0, 8'h00, 8'h08, 1'h0, 16'h0009, 16'h000A},
		'{4'hF, 2'h0, 1'h1, 1'h0, 8'h00, 8'h02, 1'h1, 16'h8001, 16'h8001},
		'{4'hB, 2'h0, 1'h0, 1'h1, 8'h01, 8'h04, 1'h1, 16'h0ABC, 16'h0ABC},
		'{4'h7, 2'h1, 1'h0, 1'h0, 8'h01, 8'h04, 1'h1, 16'h00F0, 16'h00F0},
		'{4'h4, 2'h2, 1'h0, 1'h0, 8'h01, 8'h04, 1'h1, 16'h0015, 16'h0015},
		'{4'h7, 2'h0, 1'h1, 1'h1, 8'h02, 8'h02, 1'h1, 16'h00C3, 16'h00C3}};

	// ==========================================
	// wire levels: released lines fall back to bench or peer
	assign sclk_w = pins_out.sclk_oe_n ? 1'h0 : pins_out.sclk; // slave clock left still
	assign mosi_w = pins_out.mosi_oe_n ? cyc[0] : pins_out.mosi; // released line keeps moving
	assign ssel_w = pins_out.ssel_oe_n ? tb_ssel_n : pins_out.ssel;
	assign miso_w = pins_out.miso_oe_n ? peer_miso : pins_out.miso;
	assign pins_in = {sclk_w, mosi_w, miso_w, ssel_w};

	ssc_core i_ssc_core (.ref_clk(ref_clk), .rstn(rstn), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .pins_in(pins_in),
		.pins_out(pins_out));
	ssc_peer i_ssc_peer (.sclk(sclk_w), .mosi(mosi_w), .ssel_n(ssel_w), .miso(peer_miso), .rx_word(peer_rx),
		.nbits(peer_n));

	// ==========================================
	// clock, cycle count and bus clock period
	initial begin
		ref_clk = 1'h0;
		forever #10 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) cyc <= cyc + 1;
	always @(posedge pins_out.sclk) begin
		per = cyc - last_rise;
		last_rise = cyc;
	end

	// ==========================================
	// tasks
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_tests++;
		if (got !== ex) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk

	// request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		int k;
		k = 0;
		@(posedge ref_clk);
		address <= a;
		writedata <= d;
		read <= !wr;
		write <= wr;
		@(posedge ref_clk);
		// accept edge: waitrequest seen low at a rising edge
		while (waitrequest !== 1'h0 && k < 50) begin
			k++;
			@(posedge ref_clk);
		end
		if (k >= 50) begin
			err_count++;
		end
		q = readdata;
		read <= 1'h0;
		write <= 1'h0;
	endtask : bus

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'h1, a, d, q);
		// let the write settle before pins are looked at
		@(negedge ref_clk);
	endtask : wr

	task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] m, input logic [31:0] ex);
		logic [31:0] q;
		bus(1'h0, a, 32'h0000_0000, q);
		chk(nm, ex, q & m);
	endtask : rdc

	// poll status until the busy bit drops
	task automatic idle();
		logic [31:0] q;
		int k;
		k = 0;
		q = 32'h0000_0010;
		while (q[4] !== 1'h0 && k < 3000) begin
			bus(1'h0, `SSC_ADR_STAT, 32'h0000_0000, q);
			k++;
		end
		if (k >= 3000) begin
			err_count++;
		end
	endtask : idle

	task automatic summarize();
		$display("checks %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : summarize

	// ==========================================
	// watchdog, generous against the longest fill and drain
	initial begin
		repeat (60000) @(posedge ref_clk);
		err_count++;
		summarize();
	end

	// ==========================================
	// main sequence
	initial begin
		ssc_row_s r;
		rstn = 1'h0;
		read = 1'h0;
		write = 1'h0;
		address = 32'h0000_0000;
		writedata = 32'h0000_0000;
		tb_ssel_n = 1'h1;
		err_count = 0;
		n_tests = 0;
		repeat (10) @(posedge ref_clk);
		rstn <= 1'h1;
		rdc("status reset", `SSC_ADR_STAT, 32'h0000_001F, 32'h0000_0003);
		rdc("ctrl one reset", `SSC_ADR_CTRL1, 32'h0000_000F, 32'h0000_0000);
		// one frame per row, configured before enabling
		for (int i = 0; i < 8; i++) begin
			r = rows[i];
			wr(`SSC_ADR_CTRL1, 32'h0000_0000);
			wr(`SSC_ADR_PRESC, {24'h00_0000, r.pre});
			wr(`SSC_ADR_CTRL0, {16'h0000, r.rate, r.pha, r.pol, r.fmt, r.sz});
			wr(`SSC_ADR_CTRL1, {30'h0, 1'h1, r.lp});
			wr(`SSC_ADR_DATA, {16'h0000, r.tx});
			idle();
			rdc("rx frame", `SSC_ADR_DATA, 32'hFFFF_FFFF, {16'h0000, r.ex});
			chk("clock idle", {31'h0, r.pol}, {31'h0, pins_out.sclk});
			if (!r.lp) begin
				chk("peer bits", 32'(r.sz) + 32'h1, {27'h0, peer_n});
				chk("peer word", {16'h0000, r.tx}, {16'h0000, peer_rx});
				chk("bit period", 32'(r.pre) * (32'(r.rate) + 32'h1), per);
			end
		end
		// master drives clock, data out and select; role locked while on
		wr(`SSC_ADR_CTRL1, 32'h0000_0002);
		chk("master oe", 32'h2, {28'h0, pins_out.sclk_oe_n, pins_out.mosi_oe_n, pins_out.miso_oe_n,
			pins_out.ssel_oe_n});
		wr(`SSC_ADR_CTRL1, 32'h0000_0006);
		rdc("role locked", `SSC_ADR_CTRL1, 32'h0000_000F, 32'h0000_0002);
		// prompt start and busy while shifting
		wr(`SSC_ADR_CTRL1, 32'h0000_0000);
		wr(`SSC_ADR_CTRL0, 32'h0000_0307);
		wr(`SSC_ADR_PRESC, 32'h0000_0004);
		wr(`SSC_ADR_CTRL1, 32'h0000_0002);
		wr(`SSC_ADR_DATA, 32'h0000_00AA);
		repeat (3) @(negedge ref_clk);
		chk("frame start", 32'h0, {31'h0, ssel_w});
		rdc("status busy", `SSC_ADR_STAT, 32'h0000_001F, 32'h0000_0013);
		idle();
		rdc("rx peer", `SSC_ADR_DATA, 32'hFFFF_FFFF, 32'h0000_00A5);
		// fill while disabled, ninth word refused, then drain in order
		wr(`SSC_ADR_CTRL1, 32'h0000_0001);
		for (int i = 0; i < 9; i++) wr(`SSC_ADR_DATA, 32'h0000_0010 + 32'(i));
		rdc("status full", `SSC_ADR_STAT, 32'h0000_001F, 32'h0000_0010);
		wr(`SSC_ADR_CTRL1, 32'h0000_0003);
		idle();
		rdc("status rx full", `SSC_ADR_STAT, 32'h0000_001F, 32'h0000_000F);
		for (int i = 0; i < 8; i++) rdc("drain", `SSC_ADR_DATA, 32'hFFFF_FFFF, 32'h0000_0010 + 32'(i));
		rdc("status drained", `SSC_ADR_STAT, 32'h0000_001F, 32'h0000_0003);
		// slave role: only the return line is driven, unless blocked
		wr(`SSC_ADR_CTRL1, 32'h0000_0000);
		wr(`SSC_ADR_CTRL1, 32'h0000_0006);
		@(posedge ref_clk);
		tb_ssel_n <= 1'h0;
		repeat (4) @(negedge ref_clk);
		chk("slave oe", 32'hD, {28'h0, pins_out.sclk_oe_n, pins_out.mosi_oe_n, pins_out.miso_oe_n,
			pins_out.ssel_oe_n});
		wr(`SSC_ADR_CTRL1, 32'h0000_000E);
		@(negedge ref_clk);
		chk("slave block", 32'h1, {31'h0, pins_out.miso_oe_n});
		@(posedge ref_clk);
		tb_ssel_n <= 1'h1;
		summarize();
	end
endmodule : tb_top
`default_nettype wire

// File: verilog/ssc_core.sv
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
`include "ssc_map.svh"
// ==========================================
module ssc_core
	import ssc_pkg::*;
(
	input  wire logic         ref_clk,     // 50 MHz clock
	input  wire logic         rstn,        // async reset, low
	input  wire logic [31:0]  address,     // byte address
	input  wire logic         read,        // read request
	input  wire logic         write,       // write request
	input  wire logic [31:0]  writedata,   // write data
	output var  logic [31:0]  readdata,    // read data
	output logic              waitrequest, // stall request
	input  wire ssc_pin_in_s  pins_in,     // serial pins in
	output ssc_pin_out_s      pins_out     // serial pins out
);
	ssc_ctrl0_s           ctrl0;
	ssc_ctrl1_s           ctrl1;
	logic [7:0]           presc;
	logic                 ack;
	ssc_pin_in_s          sync1;
	ssc_pin_in_s          sync2;
	logic                 sclk_d;
	ssc_state_e           st;
	ssc_state_e           next_st;
	logic [4:0]           ecnt;
	logic [6:0]           pre_cnt;
	logic [7:0]           scr_cnt;
	logic [15:0]          tx_sr;
	logic [15:0]          rx_sr;
	logic                 sclk_lvl;
	logic                 done_d;
	ssc_stat_s            stat;
	logic                 req;
	logic                 acc;
	logic                 sel_c0;
	logic                 sel_c1;
	logic                 sel_dr;
	logic                 sel_st;
	logic                 sel_ps;
	logic [31:0]          rd_mux;
	logic                 tx_push;
	logic                 tx_room;
	logic                 tx_valid;
	logic                 tx_pop;
	logic [15:0]          tx_word;
	logic [3:0]           tx_cnt;
	logic                 rx_ready;
	logic                 rx_valid;
	logic                 rx_pop;
	logic [15:0]          rx_word;
	logic [15:0]          rx_in;
	logic [3:0]           rx_cnt;
	logic                 en;
	logic                 master;
	logic                 fmt_spi;
	logic                 eff_clock_idle_level;
	logic                 eff_capture_edge_select;
	logic [3:0]           size_eff;
	logic [4:0]           last_e;
	logic [6:0]           half_div;
	logic                 half_tick;
	logic                 ssel_low_in;
	logic                 start;
	logic                 edge_go;
	logic                 last_go;
	logic                 sample_e;
	logic                 shift_e;
	logic                 tx_bit;
	logic                 din;
	logic                 drive_m;
	logic                 drive_s;

	// address match, shared by read and write decode
	function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
		return a == r;
	endfunction : hit

	// ones in the low size+1 bits
	function automatic logic [15:0] frame_mask(input logic [3:0] sz);
		return 16'hFFFF >> (4'hF - sz);
	endfunction : frame_mask

	// ==========================================
	// avalon slave: one wait cycle, then accept
	assign req         = read | write;
	assign waitrequest = req & ~ack;
	assign acc         = req & ack;
	assign sel_c0      = hit(address, `SSC_ADR_CTRL0);
	assign sel_c1      = hit(address, `SSC_ADR_CTRL1);
	assign sel_dr      = hit(address, `SSC_ADR_DATA);
	assign sel_st      = hit(address, `SSC_ADR_STAT);
	assign sel_ps      = hit(address, `SSC_ADR_PRESC);

	// unmapped addresses read zero; reserved bits read zero
	assign rd_mux = sel_c0 ? {16'h0000, ctrl0} :
		sel_c1 ? {28'h000_0000, ctrl1} :
		sel_dr ? {16'h0000, rx_word} :
		sel_st ? {27'h000_0000, stat} :
		sel_ps ? {24'h00_0000, presc} : 32'h0000_0000;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ack      <= 1'b0;
			readdata <= 32'h0000_0000;
		end else begin
			ack <= req & ~ack;
			if (req & ~ack) begin
				readdata <= rd_mux;
			end
		end
	end

	// ==========================================
	// control registers, written at the accept edge
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl0 <= `SSC_CTRL0_RST;
			ctrl1 <= `SSC_CTRL1_RST;
			presc <= `SSC_PRESC_RST;
		end else if (write & acc) begin
			if (sel_c0) begin
				ctrl0 <= writedata[15:0];
			end
			if (sel_c1) begin
				ctrl1.loopback <= writedata[`SSC_C1_LOOP];
				ctrl1.enable   <= writedata[`SSC_C1_EN];
				ctrl1.block    <= writedata[`SSC_C1_BLOCK];
				if (!ctrl1.enable) begin
					ctrl1.role <= writedata[`SSC_C1_ROLE];
				end
			end
			if (sel_ps) begin
				presc <= {writedata[7:1], 1'b0}; // even only
			end
		end
	end

	// ==========================================
	// fifos: data port pushes on write, pops on read
	assign tx_push = write & acc & sel_dr;
	assign rx_pop  = read & acc & sel_dr;
	assign tx_pop  = start;

	ssc_fifo u_tx_fifo (
		.ref_clk   (ref_clk),
		.rstn      (rstn),
		.in_valid  (tx_push),
		.in_ready  (tx_room),
		.in_data   (writedata[15:0]),
		.out_valid (tx_valid),
		.out_ready (tx_pop),
		.out_data  (tx_word),
		.count     (tx_cnt)
	);

	ssc_fifo u_rx_fifo (
		.ref_clk   (ref_clk),
		.rstn      (rstn),
		.in_valid  (done_d),
		.in_ready  (rx_ready),
		.in_data   (rx_in),
		.out_valid (rx_valid),
		.out_ready (rx_pop),
		.out_data  (rx_word),
		.count     (rx_cnt)
	);

	// status flags straight from fifo levels and engine
	assign stat.tx_empty = tx_cnt == 4'h0;
	assign stat.tx_room  = tx_room;
	assign stat.rx_has   = rx_valid;
	assign stat.rx_full  = ~rx_ready;
	assign stat.busy     = (st != st_idle) | ~stat.tx_empty;

	// ==========================================
	// pin synchronisers, first stage feeds only the second
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sync1  <= '0;
			sync2  <= '0;
			sclk_d <= 1'b0;
		end else begin
			sync1  <= pins_in;
			sync2  <= sync1;
			sclk_d <= sync2.sclk;
		end
	end

	// ==========================================
	// frame shape; ti and microwire use fixed clocking
	assign en       = ctrl1.enable;
	assign master   = ~ctrl1.role;
	assign fmt_spi  = ctrl0.fmt == `SSC_FMT_SPI;
	assign eff_clock_idle_level = fmt_spi & ctrl0.clock_idle_level;
	assign eff_capture_edge_select = fmt_spi ? ctrl0.capture_edge_select : ctrl0.fmt == `SSC_FMT_TI;
	assign size_eff = (ctrl0.size < `SSC_SIZE_MIN) ? `SSC_SIZE_MIN : ctrl0.size;
	assign last_e   = {size_eff, 1'b1};

	// half bit = presc/2 * (rate+1) clocks, so bit = presc*(rate+1)
	assign half_div  = (presc[7:1] == 7'h00) ? 7'h01 : presc[7:1];
	assign half_tick = (pre_cnt == half_div - 7'h01) & (scr_cnt == ctrl0.rate);

	// dividers rest in idle so each frame starts on a clean phase
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pre_cnt <= 7'h00;
			scr_cnt <= 8'h00;
		end else if (st == st_idle) begin
			pre_cnt <= 7'h00;
			scr_cnt <= 8'h00;
		end else if (pre_cnt == half_div - 7'h01) begin
			pre_cnt <= 7'h00;
			scr_cnt <= half_tick ? 8'h00 : scr_cnt + 8'h01;
		end else begin
			pre_cnt <= pre_cnt + 7'h01;
		end
	end

	// ==========================================
	// engine triggers for both roles
	assign ssel_low_in = ~sync2.ssel;
	assign start = en & (st == st_idle) & (master ? tx_valid : ssel_low_in);
	assign edge_go = (st == st_shift) & (master ? half_tick : sync2.sclk ^ sclk_d);
	assign last_go  = edge_go & (ecnt == last_e);
	assign sample_e = eff_capture_edge_select ? ecnt[0] : ~ecnt[0];
	assign shift_e  = eff_capture_edge_select ? (~ecnt[0] & (ecnt != 5'h00)) : (ecnt[0] & ~last_go);
	assign tx_bit   = tx_sr[15];
	assign din = ctrl1.loopback ? tx_bit : (master ? sync2.miso : sync2.mosi);

	// state sequencing; losing enable aborts the frame
	always_comb begin
		next_st = st;
		case (st)
			st_idle: begin
				if (start) begin
					next_st = st_shift;
				end
			end
			st_shift: begin
				if (!en || (!master && !ssel_low_in)) begin
					next_st = st_idle;
				end else if (last_go) begin
					next_st = master ? st_tail : st_idle;
				end
			end
			st_tail: begin
				if (!en || half_tick) begin
					next_st = st_idle;
				end
			end
			default: begin
				next_st = st_idle;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st <= st_idle;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================
	// shifters; slave with empty fifo sends zeros
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			tx_sr    <= 16'h0000;
			rx_sr    <= 16'h0000;
			ecnt     <= 5'h00;
			sclk_lvl <= 1'b0;
			done_d   <= 1'b0;
		end else begin
			done_d <= last_go;
			if (st == st_idle) begin
				ecnt     <= 5'h00;
				sclk_lvl <= eff_clock_idle_level;
				if (start) begin
					tx_sr <= tx_valid ? tx_word << (4'hF - size_eff) : 16'h0000;
				end
			end else if (edge_go) begin
				ecnt     <= ecnt + 5'h01;
				sclk_lvl <= ~sclk_lvl;
				if (shift_e) begin
					tx_sr <= {tx_sr[14:0], 1'b0};
				end
				if (sample_e) begin
					rx_sr <= {rx_sr[14:0], din};
				end
			end
		end
	end

	// received word trimmed to the frame length
	assign rx_in = rx_sr & frame_mask(size_eff);

	// ==========================================
	// pin drive; enables are active low
	assign drive_m = en & master;
	assign drive_s = en & ~master & ~ctrl1.block & ssel_low_in;
	assign pins_out.sclk      = sclk_lvl;
	assign pins_out.sclk_oe_n = ~drive_m;
	assign pins_out.mosi      = tx_bit;
	assign pins_out.mosi_oe_n = ~drive_m;
	assign pins_out.miso      = tx_bit;
	assign pins_out.miso_oe_n = ~drive_s;
	// ti framing pulses select high over the first bit
	assign pins_out.ssel = (ctrl0.fmt == `SSC_FMT_TI) ?
		(st == st_shift) & (ecnt < 5'h02) : st != st_shift;
	assign pins_out.ssel_oe_n = ~drive_m;

	// ==========================================
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	logic [15:0] hgap;
	logic [15:0] gap_exp;
	assign gap_exp = {9'h000, half_div} * {8'h00, ctrl0.rate} + {9'h000, half_div};
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			hgap <= 16'h0000;
		end else begin
			hgap <= (half_tick || st == st_idle) ? 16'h0000 : hgap + 16'h0001;
		end
	end

	loop_path_a: assert property (ctrl1.loopback |-> din == tx_sr[15])
		else $error("loopback input not own output");
	idle_off_a: assert property (!en |=> st == st_idle)
		else $error("disabled engine not idle");
	role_hold_a: assert property ($changed(ctrl1.role) |-> !$past(ctrl1.enable))
		else $error("role changed while enabled");
	master_pins_a: assert property (en && master |-> !pins_out.sclk_oe_n && pins_out.miso_oe_n)
		else $error("master pin drive wrong");
	slave_pins_a: assert property (en && !master |-> pins_out.sclk_oe_n && pins_out.mosi_oe_n)
		else $error("slave drives master pins");
	block_miso_a: assert property (!master && ctrl1.block |-> pins_out.miso_oe_n)
		else $error("blocked slave drives miso");
	tx_start_a: assert property (tx_push && stat.tx_empty && st == st_idle && en && master
		|-> ##[1:2] st == st_shift)
		else $error("frame did not start");
	rd_pop_a: assert property (rx_pop && rx_valid && !done_d |=> rx_cnt == $past(rx_cnt) - 4'h1)
		else $error("read did not pop");
	rx_just_a: assert property (done_d |-> (rx_in & ~frame_mask(size_eff)) == 16'h0000)
		else $error("upper receive bits not zero");
	tx_flag_a: assert property (stat.tx_empty == (tx_cnt == 4'h0) && stat.tx_room == (tx_cnt != 4'h8))
		else $error("transmit flags wrong");
	busy_flag_a: assert property (st != st_idle |-> stat.busy)
		else $error("busy low while shifting");
	full_drop_a: assert property (write && acc && sel_dr && tx_cnt == 4'h8
		|=> tx_cnt == ($past(tx_pop) ? 4'h7 : 4'h8))
		else $error("full fifo overflowed");
	bit_rate_a: assert property (half_tick && st != st_idle && $stable(ctrl0) && $stable(presc)
		|-> hgap == gap_exp - 16'h0001)
		else $error("half bit period wrong");

	master_frame_c: cover property (en && master && last_go);
	slave_frame_c: cover property (en && !master && last_go);
	loop_frame_c: cover property (ctrl1.loopback && done_d);
	rx_full_c: cover property (stat.rx_full);
endmodule : ssc_core
`default_nettype wire

// File: verilog/ssc_fifo.sv
`timescale 1ns/1ns
`default_nettype none
`include "ssc_map.svh"
// ==========================================
// frame fifo, eight words of sixteen bits
module ssc_fifo
	import ssc_pkg::*;
(
	input  wire logic                  ref_clk,   // system clock
	input  wire logic                  rstn,      // async reset
	input  wire logic                  in_valid,  // push request
	output logic                       in_ready,  // room left
	input  wire logic [`SSC_DATA_W-1:0] in_data,  // pushed word
	output logic                       out_valid, // word held
	input  wire logic                  out_ready, // pop request
	output logic [`SSC_DATA_W-1:0]     out_data,  // oldest word
	output logic [`SSC_CNT_W-1:0]      count      // words held
);
	logic [`SSC_DATA_W-1:0] mem [`SSC_DEPTH];
	logic [`SSC_PTR_W-1:0]  wr_ptr;
	logic [`SSC_PTR_W-1:0]  rd_ptr;
	logic                   push;
	logic                   pop;

	// a push into a full fifo is dropped here
	assign in_ready  = count != `SSC_CNT_W'(`SSC_DEPTH);
	assign out_valid = count != '0;
	assign push      = in_valid & in_ready;
	assign pop       = out_ready & out_valid;
	assign out_data  = mem[rd_ptr];

	// ==========================================
	// pointers and fill level
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= wr_ptr + `SSC_PTR_W'(push);
			rd_ptr <= rd_ptr + `SSC_PTR_W'(pop);
			count  <= count + `SSC_CNT_W'(push) - `SSC_CNT_W'(pop);
		end
	end

	// storage, no reset needed on the data
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule : ssc_fifo
`default_nettype wire

// File: verilog/ssc_map.svh
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH
// ==========================================
// register byte addresses
`define SSC_ADR_CTRL0  32'h4004_0000
`define SSC_ADR_CTRL1  32'h4004_0004
`define SSC_ADR_DATA   32'h4004_0008
`define SSC_ADR_STAT   32'h4004_000C
`define SSC_ADR_PRESC  32'h4004_0010
// ==========================================
// control one bit positions
`define SSC_C1_LOOP    0
`define SSC_C1_EN      1
`define SSC_C1_ROLE    2
`define SSC_C1_BLOCK   3
// ==========================================
// reset values
`define SSC_CTRL0_RST  16'h0000
`define SSC_CTRL1_RST  4'h0
`define SSC_PRESC_RST  8'h00
// ==========================================
// frame codes and sizes
`define SSC_FMT_SPI    2'h0
`define SSC_FMT_TI     2'h1
`define SSC_SIZE_MIN   4'h3
`define SSC_SIZE_MAX   4'hF
`define SSC_DATA_W     16
`define SSC_DEPTH      8
`define SSC_PTR_W      3
`define SSC_CNT_W      4
`endif

// File: verilog/ssc_pkg.sv
`default_nettype none
// ==========================================
// shared types of the serial controller
package ssc_pkg;
	// engine states, gray along idle-shift-tail
	typedef enum logic [1:0] {
		st_idle  = 2'b00,
		st_shift = 2'b01,
		st_tail  = 2'b11
	} ssc_state_e;

	// control zero, laid out as the register bits
	typedef struct packed {
		logic [7:0] rate;
		logic       capture_edge_select;
		logic       clock_idle_level;
		logic [1:0] fmt;
		logic [3:0] size;
	} ssc_ctrl0_s;

	// control one, bit 3 down to bit 0
	typedef struct packed {
		logic block;
		logic role;
		logic enable;
		logic loopback;
	} ssc_ctrl1_s;

	// status, bit 4 down to bit 0
	typedef struct packed {
		logic busy;
		logic rx_full;
		logic rx_has;
		logic tx_room;
		logic tx_empty;
	} ssc_stat_s;

	typedef struct packed {
		logic sclk;
		logic mosi;
		logic miso;
		logic ssel;
	} ssc_pin_in_s;

	// each pin: value then active-low enable
	typedef struct packed {
		logic sclk;
		logic sclk_oe_n;
		logic mosi;
		logic mosi_oe_n;
		logic miso;
		logic miso_oe_n;
		logic ssel;
		logic ssel_oe_n;
	} ssc_pin_out_s;
endpackage : ssc_pkg
`default_nettype wire
